/* File: design/logon_desc_builder.sv */
// Hub-side builder that assembles and streams the logon initialisation descriptor
`timescale 1ns/1ps
`default_nettype none
`include "logon_desc_map.svh"

module logon_desc_builder
    import logon_desc_pkg::*;
#(
    parameter logic [7:0] DESC_TAG = `LID_TAG_DEFAULT,
    parameter int         DEPTH    = 16,
    parameter int         AW       = 4
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        start,           // Build and send one descriptor
    input  wire logic        encrypt,         // Message will be encrypted
    input  wire logic [7:0]  terminalA,       // Group identifier
    input  wire logic [15:0] terminalB,       // Logon identifier
    input  wire logic        secHandshake,    // Security handshake required
    input  wire logic        prefixMethod,    // Prefix method in use
    input  wire logic        unitLabelling,   // Data unit labelling in use
    input  wire logic        miniSlot,        // Mini-slot method in use
    input  wire logic        contMiniSlot,    // Contention mini-slot in use
    input  wire logic        burstType,       // 0 ATM cells, 1 transport stream
    input  wire logic        connectivity,    // 0 IP, 1 ATM
    input  wire logic [7:0]  retPathId,       // Return path identifier
    input  wire logic [15:0] retChanId,       // Return channel identifier
    input  wire logic [7:0]  retSigPathId,    // Return signalling path
    input  wire logic [15:0] retSigChanId,    // Return signalling channel
    input  wire logic [7:0]  fwdSigPathId,    // Forward signalling path
    input  wire logic [15:0] fwdSigChanId,    // Forward signalling channel
    input  wire logic [12:0] retTrafficPid,   // Return traffic PID
    input  wire logic [12:0] retControlPid,   // Return control PID
    input  wire logic        txReady,         // Downstream takes a byte
    output logic      [7:0]  txData,          // Descriptor byte
    output logic             txValid,         // Byte valid
    output logic             txFirst,         // Tag byte
    output logic             txLast,          // Final byte
    output logic             busy,            // Build or send in progress
    output logic             done             // One-cycle end pulse
);

    // Control state
    build_state_e  state_reg,  state_next;   // Sequencer
    logic [AW-1:0] idx_reg,    idx_next;     // Byte index
    logic [AW-1:0] lastIdx_reg, lastIdx_next; // Index of final byte
    logic [7:0]    len_reg,    len_next;     // Length byte value
    logic          enc_reg,    enc_next;     // Latched encrypt
    // Latched fields
    logic [7:0]    grp_reg,    grp_next;
    logic [15:0]   lid_reg,    lid_next;
    method_flags_s flg_reg,    flg_next;
    logic          bt_reg,     bt_next;
    logic          conn_reg,   conn_next;
    logic [7:0]    path_reg,   path_next;    // Return or return signalling path
    logic [15:0]   chan_reg,   chan_next;    // Return or return signalling channel
    logic [7:0]    fPath_reg,  fPath_next;
    logic [15:0]   fChan_reg,  fChan_next;
    logic [12:0]   tPid_reg,   tPid_next;
    logic [12:0]   cPid_reg,   cPid_next;
    // Output registers
    logic [7:0]    txData_reg, txData_next;
    logic          txValid_reg, txValid_next;
    logic          txFirst_reg, txFirst_next;
    logic          txLast_reg,  txLast_next;
    logic          done_reg,    done_next;
    logic          busy_reg,    busy_next;   // Build or send in progress
    // Datapath helpers
    logic [7:0]    fillByte;     // Random reserved fill
    logic [7:0]    rsv;          // Reserved fill in use
    logic [7:0]    byteVal;      // Byte for current index
    logic [7:0]    newLen;       // Length for the request
    logic [7:0]    rdData;       // Stored byte
    logic          building;     // Writing the store

    assign building = (state_reg == ST_BUILD);

    // Random source advances once per built byte
    reserved_fill u_fill (
        .core_clk (core_clk),
        .rst      (rst),
        .step     (building),
        .fillByte (fillByte)
    );

    // Descriptor byte store
    desc_byte_ram #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_ram (
        .core_clk (core_clk),
        .rst      (rst),
        .wrEn     (building),
        .wrAddr   (idx_reg),
        .wrData   (byteVal),
        .rdAddr   (idx_next),
        .rdData   (rdData)
    );

    // Length of the requested layout
    always_comb begin
        if (burstType) begin
            newLen = unitLabelling ? `LID_LEN_TS_CTRL : `LID_LEN_TS;
        end else begin
            newLen = connectivity ? `LID_LEN_ATM_SIG : `LID_LEN_ATM_IP;
        end
    end

    // Reserved bits: random when encrypted, else zero
    assign rsv = enc_reg ? fillByte : 8'h00;

    // Byte at the current index
    always_comb begin
        byteVal = 8'h00;
        unique case (idx_reg)
            `LID_OFS_TAG:      byteVal = DESC_TAG;
            `LID_OFS_LEN:      byteVal = len_reg;
            `LID_OFS_GROUP:    byteVal = grp_reg;
            `LID_OFS_LOGON_HI: byteVal = lid_reg[15:8];
            `LID_OFS_LOGON_LO: byteVal = lid_reg[7:0];
            // Three reserved then five flags
            `LID_OFS_FLAGS:    byteVal = (rsv & `LID_RSV_FLAGS) | {3'h0, flg_reg};
            // Two reserved, burst type, then connectivity or PID high
            `LID_OFS_BURST: begin
                if (bt_reg) begin
                    byteVal = (rsv & `LID_RSV_BURST) | {3'h1, tPid_reg[12:8]};
                end else begin
                    byteVal = (rsv & (`LID_RSV_BURST | `LID_RSV_PATH))
                            | {2'h0, 1'b0, conn_reg, 4'h0};
                end
            end
            // Path identifier or PID low
            `LID_OFS_PATH:     byteVal = bt_reg ? tPid_reg[7:0] : path_reg;
            `LID_OFS_CHAN_HI: begin
                if (bt_reg) begin
                    byteVal = (rsv & `LID_RSV_CTRL_PID) | {3'h0, cPid_reg[12:8]};
                end else begin
                    byteVal = chan_reg[15:8];
                end
            end
            `LID_OFS_CHAN_LO:     byteVal = bt_reg ? cPid_reg[7:0] : chan_reg[7:0];
            // Eight reserved before the forward path
            `LID_OFS_FWD_RSV:     byteVal = rsv;
            `LID_OFS_FWD_PATH:    byteVal = fPath_reg;
            `LID_OFS_FWD_CHAN_HI: byteVal = fChan_reg[15:8];
            `LID_OFS_FWD_CHAN_LO: byteVal = fChan_reg[7:0];
            default:              byteVal = 8'h00;
        endcase
    end

    // Sequencer and field capture, next values
    always_comb begin
        state_next   = state_reg;
        idx_next     = idx_reg;
        lastIdx_next = lastIdx_reg;
        len_next     = len_reg;
        enc_next     = enc_reg;
        grp_next     = grp_reg;
        lid_next     = lid_reg;
        flg_next     = flg_reg;
        bt_next      = bt_reg;
        conn_next    = conn_reg;
        path_next    = path_reg;
        chan_next    = chan_reg;
        fPath_next   = fPath_reg;
        fChan_next   = fChan_reg;
        tPid_next    = tPid_reg;
        cPid_next    = cPid_reg;
        txData_next  = txData_reg;
        txValid_next = txValid_reg;
        txFirst_next = txFirst_reg;
        txLast_next  = txLast_reg;
        done_next    = 1'b0;
        unique case (state_reg)
            // Capture a request; starts while busy are ignored
            ST_IDLE: begin
                if (start) begin
                    state_next   = ST_BUILD;
                    idx_next     = '0;
                    len_next     = newLen;
                    lastIdx_next = AW'(newLen + 8'h01);
                    enc_next     = encrypt;
                    grp_next     = terminalA;
                    lid_next     = terminalB;
                    flg_next     = '{secHandshake, prefixMethod, unitLabelling,
                                     miniSlot, contMiniSlot};
                    bt_next      = burstType;
                    conn_next    = burstType ? 1'b0 : connectivity;
                    path_next    = connectivity ? retSigPathId : retPathId;
                    chan_next    = connectivity ? retSigChanId : retChanId;
                    fPath_next   = fwdSigPathId;
                    fChan_next   = fwdSigChanId;
                    tPid_next    = retTrafficPid;
                    cPid_next    = retControlPid;
                end
            end
            // One byte written to the store per cycle
            ST_BUILD: begin
                if (idx_reg == lastIdx_reg) begin
                    state_next = ST_FETCH;
                    idx_next   = '0;
                end else begin
                    idx_next = idx_reg + AW'(1);
                end
            end
            // Stored byte has arrived; present it
            ST_FETCH: begin
                state_next   = ST_SEND;
                txData_next  = rdData;
                txValid_next = 1'b1;
                txFirst_next = (idx_reg == '0);
                txLast_next  = (idx_reg == lastIdx_reg);
            end
            // Hold byte until downstream takes it
            ST_SEND: begin
                if (txReady) begin
                    txValid_next = 1'b0;
                    txFirst_next = 1'b0;
                    txLast_next  = 1'b0;
                    if (txLast_reg) begin
                        state_next = ST_IDLE;
                        done_next  = 1'b1;
                    end else begin
                        state_next = ST_FETCH;
                        idx_next   = idx_reg + AW'(1);
                    end
                end
            end
        endcase
        // Busy follows the next state so the output is a flop
        busy_next = (state_next != ST_IDLE);
    end

    // Sequencer and field registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            idx_reg     <= '0;
            lastIdx_reg <= '0;
            len_reg     <= 8'h00;
            enc_reg     <= 1'b0;
            grp_reg     <= 8'h00;
            lid_reg     <= 16'h0000;
            flg_reg     <= '0;
            bt_reg      <= 1'b0;
            conn_reg    <= 1'b0;
            path_reg    <= `LID_SIG_PATH_DEF;
            chan_reg    <= `LID_SIG_CHAN_DEF;
            fPath_reg   <= `LID_SIG_PATH_DEF;
            fChan_reg   <= `LID_SIG_CHAN_DEF;
            tPid_reg    <= 13'h0000;
            cPid_reg    <= 13'h0000;
            txData_reg  <= 8'h00;
            txValid_reg <= 1'b0;
            txFirst_reg <= 1'b0;
            txLast_reg  <= 1'b0;
            done_reg    <= 1'b0;
            busy_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            idx_reg     <= idx_next;
            lastIdx_reg <= lastIdx_next;
            len_reg     <= len_next;
            enc_reg     <= enc_next;
            grp_reg     <= grp_next;
            lid_reg     <= lid_next;
            flg_reg     <= flg_next;
            bt_reg      <= bt_next;
            conn_reg    <= conn_next;
            path_reg    <= path_next;
            chan_reg    <= chan_next;
            fPath_reg   <= fPath_next;
            fChan_reg   <= fChan_next;
            tPid_reg    <= tPid_next;
            cPid_reg    <= cPid_next;
            txData_reg  <= txData_next;
            txValid_reg <= txValid_next;
            txFirst_reg <= txFirst_next;
            txLast_reg  <= txLast_next;
            done_reg    <= done_next;
            busy_reg    <= busy_next;
        end
    end

    // Outputs straight from flops
    assign txData  = txData_reg;
    assign txValid = txValid_reg;
    assign txFirst = txFirst_reg;
    assign txLast  = txLast_reg;
    assign busy    = busy_reg;
    assign done    = done_reg;

endmodule : logon_desc_builder
`default_nettype wire

/* File: design/logon_desc_map.svh */
// Byte offsets, lengths, reserved masks and defaults of the logon descriptor builder
`ifndef LOGON_DESC_MAP_SVH
`define LOGON_DESC_MAP_SVH

// Descriptor tag default; the real tag comes from the tag table outside this block
`define LID_TAG_DEFAULT      8'h00

// Byte offsets inside the descriptor
`define LID_OFS_TAG          4'h0
`define LID_OFS_LEN          4'h1
`define LID_OFS_GROUP        4'h2
`define LID_OFS_LOGON_HI     4'h3
`define LID_OFS_LOGON_LO     4'h4
`define LID_OFS_FLAGS        4'h5
`define LID_OFS_BURST        4'h6
`define LID_OFS_PATH         4'h7
`define LID_OFS_CHAN_HI      4'h8
`define LID_OFS_CHAN_LO      4'h9
`define LID_OFS_FWD_RSV      4'hA
`define LID_OFS_FWD_PATH     4'hB
`define LID_OFS_FWD_CHAN_HI  4'hC
`define LID_OFS_FWD_CHAN_LO  4'hD

// Length byte values: bytes that follow the length byte
`define LID_LEN_ATM_IP       8'h08
`define LID_LEN_ATM_SIG      8'h0C
`define LID_LEN_TS           8'h06
`define LID_LEN_TS_CTRL      8'h08

// Reserved bit masks, leading bits of each byte except LID_RSV_PATH, which covers the trailing four bits
`define LID_RSV_FLAGS        8'hE0
`define LID_RSV_BURST        8'hC0
`define LID_RSV_PATH         8'h0F
`define LID_RSV_CTRL_PID     8'hE0

// Default connection-signalling circuit 0/5
`define LID_SIG_PATH_DEF     8'h00
`define LID_SIG_CHAN_DEF     16'h0005

// Seed of the reserved-bit scrambler
`define LID_FILL_SEED        16'hACE1

`endif

/* File: design/logon_desc_pkg.sv */
// Types shared by the logon descriptor builder
package logon_desc_pkg;

    // Builder states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_BUILD = 4'h2,
        ST_FETCH = 4'h4,
        ST_SEND  = 4'h8
    } build_state_e;

    // Network method flags in their byte order
    typedef struct packed {
        logic secHandshake;
        logic prefixMethod;
        logic unitLabelling;
        logic miniSlot;
        logic contentionMiniSlot;
    } method_flags_s;

endpackage : logon_desc_pkg

/* File: design/reserved_fill.sv */
// Pseudo-random byte source for reserved bits of encrypted messages
`timescale 1ns/1ps
`default_nettype none
`include "logon_desc_map.svh"

module reserved_fill #(
    parameter logic [15:0] SEED = `LID_FILL_SEED
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       step,      // Advance one state
    output logic      [7:0] fillByte   // Current random byte
);

    logic [15:0] lfsr_reg;   // Galois shift state
    logic [15:0] lfsr_next;  // Next state

    // Galois step, taps 16,14,13,11
    always_comb begin
        lfsr_next = lfsr_reg;
        if (step) begin
            lfsr_next = {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hB400 : 16'h0000);
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lfsr_reg <= SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    assign fillByte = lfsr_reg[7:0];

endmodule : reserved_fill
`default_nettype wire

/* File: design/desc_byte_ram.sv */
// Small byte store holding one assembled descriptor, registered read
`timescale 1ns/1ps
`default_nettype none

module desc_byte_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             wrEn,    // Write strobe
    input  wire logic [AW-1:0]    wrAddr,  // Write address
    input  wire logic [WIDTH-1:0] wrData,  // Write data
    input  wire logic [AW-1:0]    rdAddr,  // Read address, sampled each edge
    output logic      [WIDTH-1:0] rdData   // Read data, registered
);

    logic [WIDTH-1:0] mem [DEPTH];  // Storage, no reset needed

    // Write port
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule : desc_byte_ram
`default_nettype wire

/* File: bench/logon_desc_builder_monitor.sv */
// Port-level checker for the logon descriptor builder
`timescale 1ns/1ps
`default_nettype none

module logon_desc_builder_monitor #(
    parameter logic [7:0] DESC_TAG = 8'h00
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       start,
    input wire logic       txReady,
    input wire logic [7:0] txData,
    input wire logic       txValid,
    input wire logic       txFirst,
    input wire logic       txLast,
    input wire logic       busy,
    input wire logic       done
);
    logic [7:0] idxReg;  // Offset of the byte now on the bus
    logic [7:0] lenReg;  // Length byte of this descriptor
    logic       take;    // Byte handed over this cycle

    assign take = txValid && txReady;

    // Track byte offset and length of the descriptor in flight
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idxReg <= 8'h00;
            lenReg <= 8'h00;
        end else if (take) begin
            idxReg <= txFirst ? 8'h01 : idxReg + 8'h01;
            if (idxReg == 8'h01 && !txFirst) begin
                lenReg <= txData;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Accepted request, then a quiet build phase
    sequence s_req; !busy && start; endsequence
    sequence s_quiet; (busy && !txValid) [*8]; endsequence

    property p_launch; s_req |=> s_quiet ##[1:10] (txValid && txFirst); endproperty
    a_launch: assert property (p_launch) else $error("first byte not in time");
    property p_tag; txValid && txFirst |-> txData == DESC_TAG; endproperty
    a_tag: assert property (p_tag) else $error("first byte is not the tag");
    property p_len;
        take && txFirst |-> ##2 (txValid && !txFirst && txData inside {8'h06, 8'h08, 8'h0C});
    endproperty
    a_len: assert property (p_len) else $error("length byte wrong");
    property p_last; txValid && txLast |-> !txFirst && idxReg == lenReg + 8'h01; endproperty
    a_last: assert property (p_last) else $error("final byte not at length");
    property p_hold;
        txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast) && $stable(txFirst);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_gap; take && !txLast |=> !txValid ##1 txValid; endproperty
    a_gap: assert property (p_gap) else $error("next byte spacing wrong");
    property p_done; take && txLast |=> done && !busy && !txValid ##1 !done; endproperty
    a_done: assert property (p_done) else $error("end pulse wrong");
    property p_conn;
        txValid && !txFirst && idxReg == 8'h06 && lenReg == 8'h0C |-> txData[5:4] == 2'b01;
    endproperty
    a_conn: assert property (p_conn) else $error("burst or connectivity bit wrong");
    property p_ts; txValid && !txFirst && idxReg == 8'h06 && lenReg == 8'h06 |-> txData[5]; endproperty
    a_ts: assert property (p_ts) else $error("burst type bit wrong");
endmodule : logon_desc_builder_monitor

bind logon_desc_builder logon_desc_builder_monitor #(.DESC_TAG(DESC_TAG)) i_monitor (
    .core_clk(core_clk), .rst(rst), .start(start), .txReady(txReady),
    .txData(txData), .txValid(txValid), .txFirst(txFirst), .txLast(txLast),
    .busy(busy), .done(done)
);

`default_nettype wire

/* File: bench/terminal_model.sv */
// Terminal-side sink that takes and decodes the descriptor stream
`timescale 1ns/1ps
`default_nettype none

module terminal_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       slow,         // Stall between bytes
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic       txFirst,
    output logic            txReady,
    output logic      [7:0] rxByte [16],  // Bytes by offset
    output logic      [4:0] rxCount,      // Bytes taken
    output logic      [7:0] gotA,         // Decoded terminal_a
    output logic     [15:0] gotB,         // Decoded terminal_b
    output logic            connAtm,      // Decoded connectivity
    output logic            shortErr      // Length ends early
);
    logic [1:0] waitReg;  // Stall phase counter

    // Ready pattern and byte capture; tag byte restarts the frame
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txReady <= 1'b0;
            waitReg <= 2'h0;
            rxCount <= 5'h0;
        end else begin
            waitReg <= waitReg + 2'h1;
            txReady <= !slow || waitReg == 2'h2;
            if (txValid && txReady) begin
                rxByte[txFirst ? 5'h0 : rxCount] <= txData;
                rxCount <= txFirst ? 5'h1 : rxCount + 5'h1;
            end
        end
    end

    // Field decode with reserved bits masked off
    assign gotA = rxByte[2];
    assign gotB = {rxByte[3], rxByte[4]};
    assign connAtm = !rxByte[6][5] && rxByte[6][4];
    assign shortErr = rxCount < 5'(rxByte[1]) + 5'h2;
endmodule : terminal_model

`default_nettype wire

/* File: bench/logon_desc_builder_tb.sv */
// Self-checking bench for the logon descriptor builder
`timescale 1ns/1ps
`default_nettype none

module logon_desc_builder_tb;
    localparam logic [7:0] TAG = 8'h5C;  // Arbitrary tag value
    logic        core_clk = 1'b0;
    logic        rst, start, encrypt, secHandshake, prefixMethod, unitLabelling;
    logic        miniSlot, contMiniSlot, burstType, connectivity, txReady, slow;
    logic [7:0]  terminalA, retPathId, retSigPathId, fwdSigPathId, txData, gotA;
    logic [15:0] terminalB, retChanId, retSigChanId, fwdSigChanId, gotB;
    logic [12:0] retTrafficPid, retControlPid;
    logic        txValid, txFirst, txLast, busy, done, connAtm, shortErr;
    logic [7:0]  rxByte [16];
    logic [4:0]  rxCount;
    int          checks = 0;
    int          failures = 0;
    int          cycles = 0;

    always #12.5 core_clk = ~core_clk;

    logon_desc_builder #(.DESC_TAG(TAG)) i_dut (
        .core_clk(core_clk), .rst(rst), .start(start), .encrypt(encrypt),
        .terminalA(terminalA), .terminalB(terminalB), .secHandshake(secHandshake),
        .prefixMethod(prefixMethod), .unitLabelling(unitLabelling), .miniSlot(miniSlot),
        .contMiniSlot(contMiniSlot), .burstType(burstType), .connectivity(connectivity),
        .retPathId(retPathId), .retChanId(retChanId), .retSigPathId(retSigPathId),
        .retSigChanId(retSigChanId), .fwdSigPathId(fwdSigPathId),
        .fwdSigChanId(fwdSigChanId), .retTrafficPid(retTrafficPid),
        .retControlPid(retControlPid), .txReady(txReady), .txData(txData),
        .txValid(txValid), .txFirst(txFirst), .txLast(txLast), .busy(busy), .done(done)
    );

    terminal_model i_term (
        .core_clk(core_clk), .rst(rst), .slow(slow), .txData(txData), .txValid(txValid),
        .txFirst(txFirst), .txReady(txReady), .rxByte(rxByte), .rxCount(rxCount),
        .gotA(gotA), .gotB(gotB), .connAtm(connAtm), .shortErr(shortErr)
    );

    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // One descriptor: request, optional refused request, collect and compare
    task automatic send(input string name, input logic enc, input logic [7:0] a,
                        input logic [15:0] b, input logic [4:0] fl, input logic bt,
                        input logic cn, input logic poke, input logic sl);
        logic [7:0] exp [16];
        logic [7:0] msk [16];
        logic [7:0] rsv;
        int         n;
        int         k;
        n = bt ? (fl[2] ? 10 : 8) : (cn ? 14 : 10);
        exp = '{default: 8'h00};
        msk = '{default: 8'hFF};
        rsv = 8'h00;
        exp[0] = TAG;
        exp[1] = 8'(n - 2);
        exp[2] = a;
        {exp[3], exp[4]} = b;
        exp[5] = {3'h0, fl};
        if (enc) begin
            msk[5] = 8'h1F;
            msk[6] = bt ? 8'h3F : 8'h30;
            msk[8] = bt ? 8'h1F : 8'hFF;
            msk[10] = 8'h00;
        end
        if (bt) begin
            exp[6] = {3'h1, retTrafficPid[12:8]};
            exp[7] = retTrafficPid[7:0];
            exp[8] = {3'h0, retControlPid[12:8]};
            exp[9] = retControlPid[7:0];
        end else begin
            exp[6] = {3'h0, cn, 4'h0};
            exp[7] = cn ? retSigPathId : retPathId;
            {exp[8], exp[9]} = cn ? retSigChanId : retChanId;
            exp[11] = fwdSigPathId;
            {exp[12], exp[13]} = fwdSigChanId;
        end
        @(posedge core_clk);
        {secHandshake, prefixMethod, unitLabelling, miniSlot, contMiniSlot} <= fl;
        encrypt <= enc;
        terminalA <= a;
        terminalB <= b;
        burstType <= bt;
        connectivity <= cn;
        slow <= sl;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        if (poke) begin
            repeat (3) @(posedge core_clk);
            start <= 1'b1;
            terminalA <= ~a;
            @(posedge core_clk);
            start <= 1'b0;
        end
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check("done", 16'(done), 16'h0001);
        check("busy", 16'(busy), 16'h0000);
        check("count", 16'(rxCount), 16'(n));
        for (k = 0; k < n; k++) begin
            check($sformatf("byte%0d", k), 16'(rxByte[k] & msk[k]), 16'(exp[k] & msk[k]));
            rsv |= rxByte[k] & ~msk[k];
        end
        check("group", 16'(gotA), 16'(a));
        check("logon", gotB, b);
        check("conn", 16'(connAtm), 16'(cn & ~bt));
        check("short", 16'(shortErr), 16'h0000);
        if (enc) begin
            check("rsvFill", 16'(|rsv), 16'h0001);
        end
        $display("test %s finished, checks %0d failures %0d", name, checks, failures);
    endtask : send

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        start = 1'b0;
        encrypt = 1'b0;
        {secHandshake, prefixMethod, unitLabelling, miniSlot, contMiniSlot} = 5'h00;
        {burstType, connectivity, slow} = 3'h0;
        terminalA = 8'h00;
        terminalB = 16'h0000;
        retPathId = 8'hA5;
        retChanId = 16'h1234;
        retSigPathId = 8'h3C;
        retSigChanId = 16'hBEEF;
        fwdSigPathId = 8'h5A;
        fwdSigChanId = 16'hC0DE;
        retTrafficPid = 13'h1FFF;
        retControlPid = 13'h0001;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check("rstValid", 16'(txValid), 16'h0000);
        check("rstData", 16'(txData), 16'h0000);
        check("rstBusy", 16'(busy), 16'h0000);
        send("atm_ip", 0, 8'h00, 16'hFFFF, 5'h15, 0, 0, 0, 0);
        send("atm_conn", 0, 8'hFF, 16'h0001, 5'h0A, 0, 1, 1, 1);
        send("ts", 0, 8'h3C, 16'h8000, 5'h1B, 1, 1, 0, 1);
        send("ts_label", 0, 8'h81, 16'h4242, 5'h04, 1, 0, 1, 0);
        send("enc_conn", 1, 8'h12, 16'h3456, 5'h1F, 0, 1, 0, 1);
        send("enc_ts", 1, 8'h9A, 16'hBCDE, 5'h1F, 1, 0, 0, 0);
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check("midValid", 16'(txValid), 16'h0000);
        check("midBusy", 16'(busy), 16'h0000);
        $display("test mid_reset finished, checks %0d failures %0d", checks, failures);
        send("after_reset", 0, 8'h77, 16'h0F0F, 5'h00, 0, 0, 0, 1);
        test_done();
    end
endmodule : logon_desc_builder_tb

`default_nettype wire
